// *** include/pdc_regs.vh ***
// register map, field positions and timing constants of the peripheral disable control block
`ifndef PDC_REGS_VH
`define PDC_REGS_VH

// ----------------------------------------------------------------
// register byte offsets on the wishbone bus
// ----------------------------------------------------------------
`define PDC_OFS_CTRL        4'h0
`define PDC_OFS_STAT        4'h4
`define PDC_OFS_SET         4'h8
`define PDC_OFS_CLR         4'hc
`define PDC_ADDR_W          4

// ----------------------------------------------------------------
// field positions in peripheral_disable_ctrl_one
// ----------------------------------------------------------------
`define PDC_BIT_TIMER_FIVE  15
`define PDC_BIT_TIMER_FOUR  14
`define PDC_BIT_TIMER_THREE 13
`define PDC_BIT_TIMER_TWO   12
`define PDC_BIT_TIMER_ONE   11
`define PDC_BIT_I2C_ONE     7
`define PDC_BIT_UART_TWO    6
`define PDC_BIT_UART_ONE    5
`define PDC_BIT_SPI_TWO     4
`define PDC_BIT_SPI_ONE     3
`define PDC_BIT_CAN_TWO     2
`define PDC_BIT_CAN_ONE     1
`define PDC_BIT_ADC_ONE     0
`define PDC_BIT_PENDING     16

// ----------------------------------------------------------------
// widths, reset value and masks
// ----------------------------------------------------------------
`define PDC_REG_W           16
`define PDC_NUM_PERIPH      13
`define PDC_CTRL_RESET      16'h0000
`define PDC_CTRL_WMASK      16'hf8ff
`define PDC_PRESENT_MASK    13'h1fff

// ----------------------------------------------------------------
// timing: one instruction cycle of delay, counted in system clocks
// ----------------------------------------------------------------
`define PDC_DELAY_CLKS      4'h1
`define PDC_CNT_W           4

`endif

// *** hw/pdc_gate.v ***
// one peripheral's delayed clock-gate enable and register-access enable
`timescale 1ns/100ps
`include "pdc_regs.vh"

module pdc_gate
(
    input  wire ref_clk_i,
    input  wire rst_i,
    input  wire off_i,
    input  wire present_i,
    output wire clk_en_o,
    output wire live_o,
    output wire pending_o
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    reg                  applied_off_r;
    reg                  applied_off_nxt;
    reg [`PDC_CNT_W-1:0] cnt_r;
    reg [`PDC_CNT_W-1:0] cnt_nxt;
    reg                  clk_en_r;
    wire                 want_off;

    // absent peripherals are never enabled
    assign want_off = off_i | ~present_i;

    // count the delay once the wanted state differs from the applied one
    always @*
    begin
        applied_off_nxt = applied_off_r;
        cnt_nxt         = {`PDC_CNT_W{1'b0}};
        if (want_off != applied_off_r)
        begin
            if (cnt_r == `PDC_DELAY_CLKS - 4'h1)
                applied_off_nxt = want_off;
            else
                cnt_nxt = cnt_r + 4'h1;
        end
    end

    // registered gate enable, never glitches
    always @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            applied_off_r <= 1'b0;
            cnt_r         <= {`PDC_CNT_W{1'b0}};
            clk_en_r      <= 1'b0;
        end
        else
        begin
            applied_off_r <= applied_off_nxt;
            cnt_r         <= cnt_nxt;
            clk_en_r      <= ~applied_off_nxt & present_i;
        end
    end

    assign clk_en_o  = clk_en_r;
    assign live_o    = clk_en_r;
    assign pending_o = (want_off != applied_off_r);

endmodule // pdc_gate

// *** hw/pdc_top.v ***
// peripheral disable control register with wishbone slave and per-module clock gates
//
// Design decisions made here: the register offsets and the Wishbone slave port.
`timescale 1ns/100ps
`include "pdc_regs.vh"

// Summary of operation
// - bit 15 set stops all clocks of timer five; clear lets it run.
// - bit 14 set stops timer four clocks; clear keeps it enabled.
// - bit 13 set disables timer three; clear keeps it enabled.
// - bit 12 set disables timer two; clear enables it.
// - bit 11 set disables timer one; clear keeps it enabled.
// - bits 10 to 8 ignore writes and always read zero.
// - bits 7..0 disable i2c, uart2, uart1, spi2, spi1, can2, can1, adc.
// - every implemented bit resets to zero; gates are off during reset, present peripherals enabled one clock after it.
// - a change takes effect on the module one instruction cycle later.
// - disabled module's registers ignore writes and read invalid.
module pdc_top
(
    input  wire        ref_clk_i,
    input  wire        rst_i,
    // wishbone classic slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [3:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output wire [31:0] wb_dat_o,
    output wire        wb_ack_o,
    output wire        wb_err_o,
    // per-module clock-gate enables, high = clock runs
    output wire        timer_five_clk_en_o,
    output wire        timer_four_clk_en_o,
    output wire        timer_three_clk_en_o,
    output wire        timer_two_clk_en_o,
    output wire        timer_one_clk_en_o,
    output wire        i2c_port_one_clk_en_o,
    output wire        uart_two_clk_en_o,
    output wire        uart_one_clk_en_o,
    output wire        spi_two_clk_en_o,
    output wire        spi_one_clk_en_o,
    output wire        can_two_clk_en_o,
    output wire        can_one_clk_en_o,
    output wire        adc_one_clk_en_o,
    // per-module register access enables, same bit order as the gates
    output wire [12:0] periph_regs_live_o
);

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    reg  [`PDC_REG_W-1:0]     ctrl_r;
    reg  [`PDC_REG_W-1:0]     ctrl_nxt;
    reg                       ack_r;
    reg                       err_r;
    reg  [31:0]               dat_r;
    reg  [31:0]               dat_nxt;
    reg                       err_nxt;
    wire                      req;
    wire                      wr;
    wire                      hit_ctrl;
    wire                      hit_stat;
    wire                      hit_set;
    wire                      hit_clr;
    wire                      hit_any;
    wire [`PDC_REG_W-1:0]     lane_mask;
    wire [`PDC_REG_W-1:0]     wmask;
    wire [`PDC_NUM_PERIPH-1:0] off_vec;
    wire [`PDC_NUM_PERIPH-1:0] en_vec;
    wire [`PDC_NUM_PERIPH-1:0] live_vec;
    wire [`PDC_NUM_PERIPH-1:0] pend_vec;
    wire [`PDC_NUM_PERIPH-1:0] present_vec;
    wire [`PDC_REG_W-1:0]     stat_off;
    wire                      any_pending;

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------

    // new request only while no answer is out
    assign req      = wb_cyc_i & wb_stb_i & ~ack_r & ~err_r;
    assign wr       = req & wb_we_i;
    assign hit_ctrl = (wb_adr_i == `PDC_OFS_CTRL);
    assign hit_stat = (wb_adr_i == `PDC_OFS_STAT);
    assign hit_set  = (wb_adr_i == `PDC_OFS_SET);
    assign hit_clr  = (wb_adr_i == `PDC_OFS_CLR);
    assign hit_any  = hit_ctrl | hit_stat | hit_set | hit_clr;

    // byte lanes: sel 0 covers bits 7..0, sel 1 covers 15..8
    assign lane_mask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    assign wmask = lane_mask & `PDC_CTRL_WMASK;

    // ----------------------------------------------------------------
    // control register next value
    // ----------------------------------------------------------------

    // plain write, set alias and clear alias
    always @*
    begin
        ctrl_nxt = ctrl_r;
        if (wr & hit_ctrl)
            ctrl_nxt = (ctrl_r & ~wmask) | (wb_dat_i[`PDC_REG_W-1:0] & wmask);
        else if (wr & hit_set)
            ctrl_nxt = ctrl_r | (wb_dat_i[`PDC_REG_W-1:0] & wmask);
        else if (wr & hit_clr)
            ctrl_nxt = ctrl_r & ~(wb_dat_i[`PDC_REG_W-1:0] & wmask);
    end

    // ----------------------------------------------------------------
    // read data and error
    // ----------------------------------------------------------------

    // status: applied off state per bit plus a pending flag
    assign stat_off = {en_vec[12:8] ^ present_vec[12:8] | ~present_vec[12:8],
                       3'h0,
                       en_vec[7:0] ^ present_vec[7:0] | ~present_vec[7:0]};
    assign any_pending = |pend_vec;

    // read mux, unmapped answers with err and zero data
    always @*
    begin
        dat_nxt = 32'h0000_0000;
        err_nxt = 1'b0;
        if (req)
        begin
            if (!hit_any)
                err_nxt = 1'b1;
            else if (!wb_we_i && hit_ctrl)
                dat_nxt = {16'h0000, ctrl_r & `PDC_CTRL_WMASK};
            else if (!wb_we_i && hit_stat)
                dat_nxt = {15'h0000, any_pending, stat_off};
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------

    // all disable bits reset to zero
    always @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            ctrl_r <= `PDC_CTRL_RESET;
            ack_r  <= 1'b0;
            err_r  <= 1'b0;
            dat_r  <= 32'h0000_0000;
        end
        else
        begin
            ctrl_r <= ctrl_nxt;
            ack_r  <= req & hit_any;
            err_r  <= err_nxt;
            dat_r  <= dat_nxt;
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_err_o = err_r;
    assign wb_dat_o = dat_r;

    // ----------------------------------------------------------------
    // per-module mapping of control bits
    // ----------------------------------------------------------------

    assign off_vec[12] = ctrl_r[`PDC_BIT_TIMER_FIVE];
    assign off_vec[11] = ctrl_r[`PDC_BIT_TIMER_FOUR];
    assign off_vec[10] = ctrl_r[`PDC_BIT_TIMER_THREE];
    assign off_vec[9]  = ctrl_r[`PDC_BIT_TIMER_TWO];
    assign off_vec[8]  = ctrl_r[`PDC_BIT_TIMER_ONE];
    assign off_vec[7]  = ctrl_r[`PDC_BIT_I2C_ONE];
    assign off_vec[6]  = ctrl_r[`PDC_BIT_UART_TWO];
    assign off_vec[5]  = ctrl_r[`PDC_BIT_UART_ONE];
    assign off_vec[4]  = ctrl_r[`PDC_BIT_SPI_TWO];
    assign off_vec[3]  = ctrl_r[`PDC_BIT_SPI_ONE];
    assign off_vec[2]  = ctrl_r[`PDC_BIT_CAN_TWO];
    assign off_vec[1]  = ctrl_r[`PDC_BIT_CAN_ONE];
    assign off_vec[0]  = ctrl_r[`PDC_BIT_ADC_ONE];

    assign present_vec = `PDC_PRESENT_MASK;

    // ----------------------------------------------------------------
    // clock gates, one per module
    // ----------------------------------------------------------------

    genvar g;
    generate
        for (g = 0; g < `PDC_NUM_PERIPH; g = g + 1)
        begin : gen_gate
            pdc_gate u_gate
            (
                .ref_clk_i (ref_clk_i),
                .rst_i     (rst_i),
                .off_i     (off_vec[g]),
                .present_i (present_vec[g]),
                .clk_en_o  (en_vec[g]),
                .live_o    (live_vec[g]),
                .pending_o (pend_vec[g])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // outputs to the peripherals
    // ----------------------------------------------------------------

    assign timer_five_clk_en_o   = en_vec[12];
    assign timer_four_clk_en_o   = en_vec[11];
    assign timer_three_clk_en_o  = en_vec[10];
    assign timer_two_clk_en_o    = en_vec[9];
    assign timer_one_clk_en_o    = en_vec[8];
    assign i2c_port_one_clk_en_o = en_vec[7];
    assign uart_two_clk_en_o     = en_vec[6];
    assign uart_one_clk_en_o     = en_vec[5];
    assign spi_two_clk_en_o      = en_vec[4];
    assign spi_one_clk_en_o      = en_vec[3];
    assign can_two_clk_en_o      = en_vec[2];
    assign can_one_clk_en_o      = en_vec[1];
    assign adc_one_clk_en_o      = en_vec[0];

    assign periph_regs_live_o = live_vec;

endmodule // pdc_top

// *** test/pdc_assertions.sv ***
// concurrent checks on the ports of the peripheral disable control block
`timescale 1ns/100ps
module pdc_chk
(
    input wire        ref_clk_i,
    input wire        rst_i,
    input wire        wb_cyc_i,
    input wire        wb_stb_i,
    input wire        wb_we_i,
    input wire [3:0]  wb_adr_i,
    input wire [3:0]  wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire [31:0] wb_dat_o,
    input wire        wb_ack_o,
    input wire        wb_err_o,
    input wire        timer_five_clk_en_o,
    input wire        adc_one_clk_en_o,
    input wire [12:0] periph_regs_live_o
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (rst_i);

    // request taken at this edge
    wire req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;

    // write taken on the control word
    sequence s_wr_ctrl;
        req && wb_we_i && wb_adr_i == 4'h0;
    endsequence

    // read or write taken on a mapped word
    sequence s_mapped;
        req && wb_adr_i[1:0] == 2'h0;
    endsequence

    a_mapped_ack: assert property (s_mapped |=> wb_ack_o && !wb_err_o)
        else $error("mapped access not acked next cycle");
    a_unmapped_err: assert property (req && wb_adr_i[1:0] != 2'h0 |=> wb_err_o && wb_dat_o == 32'h0)
        else $error("unmapped access not refused");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held past one cycle");
    a_rsvd_zero: assert property (wb_ack_o |-> wb_dat_o[10:8] == 3'h0 && wb_dat_o[31:17] == 15'h0)
        else $error("reserved bits read nonzero");
    a_live_gate: assert property (periph_regs_live_o[12] == timer_five_clk_en_o && periph_regs_live_o[0] == adc_one_clk_en_o)
        else $error("register access enable differs from gate");
    a_timer_delay: assert property (s_wr_ctrl ##0 wb_sel_i[1] |-> ##2 timer_five_clk_en_o == !$past(wb_dat_i[15], 2))
        else $error("timer five gate wrong after write");
    a_adc_delay: assert property (s_wr_ctrl ##0 wb_sel_i[0] |-> ##2 adc_one_clk_en_o == !$past(wb_dat_i[0], 2))
        else $error("adc gate wrong after write");
    a_no_early: assert property (s_wr_ctrl |=> $stable(periph_regs_live_o))
        else $error("gates changed before the delay");
    a_gate_cause: assert property ($changed(periph_regs_live_o) |-> $past(wb_ack_o) || $past(rst_i, 2) || $past(rst_i, 3))
        else $error("gate changed without a write");
    a_reset_open: assert property ($fell(rst_i) |-> ##[1:3] periph_regs_live_o == 13'h1fff)
        else $error("gates not open after reset");
endmodule // pdc_chk

bind pdc_top pdc_chk pdc_chk_inst (.*);

// *** test/peripheral_clock_disable_ctrl1_bench.sv ***
// self-checking bench for the peripheral disable control block
`timescale 1ns/100ps
module peripheral_clock_disable_ctrl1_bench;
    reg         ref_clk_i = 1'b0;
    reg         rst_i     = 1'b1;
    reg         wb_cyc_i  = 1'b0;
    reg         wb_stb_i  = 1'b0;
    reg         wb_we_i   = 1'b0;
    reg  [3:0]  wb_adr_i  = 4'h0;
    reg  [3:0]  wb_sel_i  = 4'h0;
    reg  [31:0] wb_dat_i  = 32'h0;
    wire [31:0] wb_dat_o;
    wire        wb_ack_o, wb_err_o, timer_five_clk_en_o, timer_four_clk_en_o, timer_three_clk_en_o;
    wire        timer_two_clk_en_o, timer_one_clk_en_o, i2c_port_one_clk_en_o, uart_two_clk_en_o;
    wire        uart_one_clk_en_o, spi_two_clk_en_o, spi_one_clk_en_o, can_two_clk_en_o, can_one_clk_en_o;
    wire        adc_one_clk_en_o;
    wire [12:0] periph_regs_live_o;
    wire [12:0] gates = {timer_five_clk_en_o, timer_four_clk_en_o, timer_three_clk_en_o, timer_two_clk_en_o,
                         timer_one_clk_en_o, i2c_port_one_clk_en_o, uart_two_clk_en_o, uart_one_clk_en_o,
                         spi_two_clk_en_o, spi_one_clk_en_o, can_two_clk_en_o, can_one_clk_en_o, adc_one_clk_en_o};
    int         n_mismatch = 0;
    int         samples_checked = 0;
    int         k;
    reg  [31:0] rd;
    reg         got_err;
    reg  [12:0] g_ack;
    reg  [15:0] ex;

    pdc_top pdc_top_inst (.*);

    // 200 MHz system clock
    initial
    begin
        forever #2.5 ref_clk_i = ~ref_clk_i;
    end

    // expected gate word for a control value
    function [31:0] gmap(input [15:0] c);
        gmap = {19'h0, ~c[15:11], ~c[7:0]};
    endfunction

    // compare one value, log a mismatch
    task chk(input string nm, input [31:0] exp, input [31:0] got);
    begin
        samples_checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    end
    endtask

    // one classic wishbone cycle, held until ack or err; only the watchdog ends a hung wait
    task wb_cycle(input we, input [3:0] adr, input [3:0] sel, input [31:0] dat);
    begin
        @(posedge ref_clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= dat;
        @(posedge ref_clk_i);
        while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1)
        begin
            @(posedge ref_clk_i);
        end
        rd = wb_dat_o;
        got_err = wb_err_o;
        g_ack = gates;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    end
    endtask

    // print counts and verdict, end the run
    task report_and_stop;
    begin
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    end
    endtask

    // reset pulse, then wait until gates settle
    task do_reset;
    begin
        @(posedge ref_clk_i);
        rst_i <= 1'b1;
        repeat (4) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        repeat (3) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
    end
    endtask

    // watchdog against a hung bus
    initial
    begin
        #20000;
        n_mismatch++;
        $display("Error watchdog expected done seen running");
        report_and_stop;
    end

    // ----------------------------------------------------------------
    // test sequence
    // ----------------------------------------------------------------
    initial
    begin
        ex = 16'h0;
        do_reset;
        chk("gates after reset", gmap(ex), gates);
        wb_cycle(1'b0, 4'h0, 4'hf, 32'h0);
        chk("ctrl after reset", 32'h0, rd);
        for (k = 0; k < 16; k++)
        begin
            if (k < 8 || k > 10)
            begin
                wb_cycle(1'b1, 4'h0, 4'h3, 32'h1 << k);
                chk("gates at ack", gmap(ex), g_ack);
                ex = 16'h1 << k;
                @(negedge ref_clk_i);
                chk("gates after write", gmap(ex), gates);
                chk("regs live", gmap(ex), periph_regs_live_o);
                wb_cycle(1'b0, 4'h0, 4'hf, 32'h0);
                chk("ctrl readback", ex, rd);
                wb_cycle(1'b0, 4'h4, 4'hf, 32'h0);
                chk("status readback", ex, rd);
            end
        end
        wb_cycle(1'b1, 4'h0, 4'h3, 32'hffff_ffff);
        wb_cycle(1'b0, 4'h0, 4'hf, 32'h0);
        chk("ctrl all ones", 32'hf8ff, rd);
        chk("gates all off", 32'h0, gates);
        wb_cycle(1'b1, 4'hc, 4'h3, 32'h8001);
        wb_cycle(1'b1, 4'h8, 4'h3, 32'h0700);
        wb_cycle(1'b0, 4'h0, 4'hf, 32'h0);
        chk("ctrl after aliases", 32'h78fe, rd);
        wb_cycle(1'b1, 4'h0, 4'h1, 32'h0);
        // a write to the status word must leave the control word alone
        wb_cycle(1'b1, 4'h4, 4'h3, 32'hffff);
        wb_cycle(1'b1, 4'h2, 4'h3, 32'hffff);
        chk("unmapped err", 32'h1, {31'h0, got_err});
        wb_cycle(1'b0, 4'h0, 4'hf, 32'h0);
        chk("ctrl low lane", 32'h7800, rd);
        chk("gates low lane", gmap(16'h7800), gates);
        do_reset;
        chk("gates after second reset", 32'h1fff, gates);
        wb_cycle(1'b0, 4'h0, 4'hf, 32'h0);
        chk("ctrl after second reset", 32'h0, rd);
        report_and_stop;
    end
endmodule // peripheral_clock_disable_ctrl1_bench
